// ==== hdl/lsag_pkg.sv ====
/*
  Shared constants, types and helpers of the load/store address generator.
  Assumes a 16-entry register file with stack pointer, link register and
  program counter at the top three indices, and a 32-bit data bus.
*/
package lsag_pkg;

  // ==========================================================================
  // Widths and register indices
  // ==========================================================================
  localparam int unsigned LSAG_XLEN      = 32;
  localparam logic [3:0]  LSAG_SP_IDX    = 4'hd;
  localparam logic [3:0]  LSAG_LR_IDX    = 4'he;
  localparam logic [3:0]  LSAG_PC_IDX    = 4'hf;
  localparam logic [31:0] LSAG_WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] LSAG_HALF_MASK = 32'hffff_fffe;
  localparam logic [31:0] LSAG_ZERO      = 32'h0000_0000;
  localparam logic [15:0] LSAG_NO_REGS   = 16'h0000;
  localparam int unsigned LSAG_BYTE_MSB  = 7;
  localparam int unsigned LSAG_HALF_MSB  = 15;

  // ==========================================================================
  // Program-counter-relative offset limits (13-bit two's complement)
  // ==========================================================================
  localparam logic signed [12:0] LSAG_PCREL_MAX = 13'sh0fff;
  localparam logic signed [12:0] LSAG_PCREL_MIN = -13'sh0fff;
  localparam logic signed [12:0] LSAG_DUAL_MAX  = 13'sh03fc;
  localparam logic signed [12:0] LSAG_DUAL_MIN  = -13'sh03fc;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [2:0] {
    LSAG_OP_REGOFF     = 3'h0,
    LSAG_OP_UNPRIV     = 3'h1,
    LSAG_OP_PCREL      = 3'h2,
    LSAG_OP_PCREL_DUAL = 3'h3,
    LSAG_OP_MULTI      = 3'h4
  } lsag_op_t;

  typedef enum logic [2:0] {
    LSAG_SZ_WORD  = 3'h0,
    LSAG_SZ_UBYTE = 3'h1,
    LSAG_SZ_UHALF = 3'h2,
    LSAG_SZ_SBYTE = 3'h3,
    LSAG_SZ_SHALF = 3'h4
  } lsag_size_t;

  // Mnemonic form of a multiple transfer, including stack aliases
  typedef enum logic [2:0] {
    LSAG_MF_DEFAULT = 3'h0,
    LSAG_MF_INC     = 3'h1,
    LSAG_MF_DEC     = 3'h2,
    LSAG_MF_FULLD   = 3'h3,
    LSAG_MF_EMPTYA  = 3'h4
  } lsag_mform_t;

  typedef enum logic {
    LSAG_DIR_INC_AFTER  = 1'b0,
    LSAG_DIR_DEC_BEFORE = 1'b1
  } lsag_dir_t;

  typedef enum logic [1:0] {
    LSAG_BUS_BYTE = 2'h0,
    LSAG_BUS_HALF = 2'h1,
    LSAG_BUS_WORD = 2'h2
  } lsag_bus_size_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Resolve default mode and stack aliases to a real direction
  function automatic lsag_dir_t lsag_multi_dir(input lsag_mform_t form,
                                               input logic        is_load);
    lsag_dir_t d;
    case (form)
      LSAG_MF_DEC:    d = LSAG_DIR_DEC_BEFORE;
      LSAG_MF_FULLD:  d = is_load ? LSAG_DIR_INC_AFTER : LSAG_DIR_DEC_BEFORE;
      LSAG_MF_EMPTYA: d = is_load ? LSAG_DIR_DEC_BEFORE : LSAG_DIR_INC_AFTER;
      default:        d = LSAG_DIR_INC_AFTER;
    endcase
    return d;
  endfunction : lsag_multi_dir

  function automatic lsag_bus_size_t lsag_bus_size(input lsag_size_t s);
    lsag_bus_size_t b;
    case (s)
      LSAG_SZ_UBYTE, LSAG_SZ_SBYTE: b = LSAG_BUS_BYTE;
      LSAG_SZ_UHALF, LSAG_SZ_SHALF: b = LSAG_BUS_HALF;
      default:                      b = LSAG_BUS_WORD;
    endcase
    return b;
  endfunction : lsag_bus_size

endpackage : lsag_pkg

// ==== hdl/lsag_extend.sv ====
/*
  Load data extension: widens a byte or halfword read to a register value.
  Assumes the narrow datum sits in the low lanes of the read data.
*/
module lsag_extend (
  // Raw read data and access size
  input  wire logic [31:0]         raw_data,
  input  wire lsag_pkg::lsag_size_t size,
  // Register-ready value
  output logic [31:0]               reg_data
);

  // ==========================================================================
  // Zero or sign extension
  // ==========================================================================
  // Pure logic; the caller registers the result
  always_comb begin
    case (size)
      lsag_pkg::LSAG_SZ_UBYTE: reg_data = {24'h00_0000, raw_data[7:0]};
      lsag_pkg::LSAG_SZ_UHALF: reg_data = {16'h0000, raw_data[15:0]};
      lsag_pkg::LSAG_SZ_SBYTE:
        reg_data = {{24{raw_data[lsag_pkg::LSAG_BYTE_MSB]}}, raw_data[7:0]};
      lsag_pkg::LSAG_SZ_SHALF:
        reg_data = {{16{raw_data[lsag_pkg::LSAG_HALF_MSB]}}, raw_data[15:0]};
      default:                 reg_data = raw_data;
    endcase
  end

endmodule : lsag_extend

// ==== hdl/lsag_core.sv ====
/*
  Address generation and sequencing for single and multiple register memory
  transfers. Takes one decoded command at a time with its register operands
  already read, runs the bus beats, and returns register writes, base
  writeback and branches. Assumes the core supplies store data for the
  register named on mem_reg_q and holds a beat's bus signals until mem_ack.
*/
// Function
// - Register offset address is base plus shifted offset
// - Narrow loads zero or sign extended
// - Signed sizes rejected on stores
// - PC load branches with bit zero cleared
// - Condition flags never written
// - Unprivileged offset 0 to 255 added
// - Unprivileged forms always flag unprivileged access
// - Unprivileged software sees ordinary behaviour
// - Dual PC-relative offset range checked; single form only against its minimum
// - Increment-after walks upward lowest register first
// - Decrement-before walks downward highest register first
// - Writeback stores final accessed address
// - Default multiple mode is increment-after
// - Stack aliases mapped to real modes
// - Multiple transfers words only, nonempty list
module lsag_core (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Command from the decoder
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready_q,
  input  wire lsag_pkg::lsag_op_t      cmd_op,
  input  wire logic                    cmd_load,
  input  wire lsag_pkg::lsag_size_t    cmd_size,
  input  wire logic                    cmd_cond_pass,
  input  wire logic                    cmd_privileged,
  input  wire logic [3:0]              cmd_xfer_reg,
  input  wire logic [3:0]              cmd_xfer2_reg,
  input  wire logic [3:0]              cmd_base_reg,
  input  wire logic [31:0]             cmd_base_val,
  input  wire logic [31:0]             cmd_offset_val,
  input  wire logic [1:0]              cmd_shift,
  input  wire logic [7:0]              cmd_unpriv_imm,
  input  wire logic [31:0]             cmd_pc_val,
  input  wire logic signed [12:0]      cmd_pc_off,
  input  wire logic [15:0]             cmd_reg_list,
  input  wire lsag_pkg::lsag_mform_t   cmd_multi_form,
  input  wire logic                    cmd_writeback,
  // Memory side
  output logic                         mem_req_q,
  output logic                         mem_write_q,
  output logic [31:0]                  mem_addr_q,
  output lsag_pkg::lsag_bus_size_t     mem_size_q,
  output logic                         mem_unpriv_q,
  output logic [3:0]                   mem_reg_q,
  input  wire logic                    mem_ack,
  input  wire logic [31:0]             mem_rdata,
  // Register file and branch results
  output logic                         rf_we_q,
  output logic [3:0]                   rf_idx_q,
  output logic [31:0]                  rf_data_q,
  output logic                         bwb_we_q,
  output logic [3:0]                   bwb_idx_q,
  output logic [31:0]                  bwb_data_q,
  output logic                         br_valid_q,
  output logic [31:0]                  br_target_q,
  // Status
  output logic                         done_q,
  output logic                         reject_q,
  output logic                         flags_we_q
);

  // ==========================================================================
  // Types and helpers
  // ==========================================================================
  typedef enum logic [1:0] {
    LSAG_ST_IDLE  = 2'b00,
    LSAG_ST_ISSUE = 2'b01,
    LSAG_ST_WAIT  = 2'b10
  } lsag_state_t;

  function automatic logic [3:0] lsag_lowest(input logic [15:0] m);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) idx = 4'(i);
    end
    return idx;
  endfunction : lsag_lowest

  function automatic logic [3:0] lsag_highest(input logic [15:0] m);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) idx = 4'(i);
    end
    return idx;
  endfunction : lsag_highest

  // ==========================================================================
  // State
  // ==========================================================================
  lsag_state_t               state_q;
  lsag_pkg::lsag_op_t        op_q;
  lsag_pkg::lsag_size_t      size_q;
  lsag_pkg::lsag_dir_t       dir_q;
  logic                      load_q;
  logic                      unpriv_q;
  logic                      wb_q;
  logic                      beat2_q;
  logic [3:0]                xfer_q;
  logic [3:0]                xfer2_q;
  logic [3:0]                base_q;
  logic [31:0]               addr_q;
  logic [15:0]               list_q;
  logic [31:0]               ext_data;

  logic                      accept;
  logic                      illegal;
  logic                      beat_ack;
  logic                      more;
  logic [3:0]                cur_reg;
  logic [15:0]               list_rest;
  logic [31:0]               start_addr;
  lsag_pkg::lsag_size_t      beat_size;

  assign accept   = cmd_valid && cmd_ready_q;
  assign beat_ack = (state_q == LSAG_ST_WAIT) && mem_ack;

  // Legality the device itself enforces; producer-side limits are trusted
  always_comb begin
    illegal = 1'b0;
    if (!cmd_load && (cmd_size == lsag_pkg::LSAG_SZ_SBYTE ||
                      cmd_size == lsag_pkg::LSAG_SZ_SHALF) &&
        cmd_op != lsag_pkg::LSAG_OP_MULTI) illegal = 1'b1;
    if (cmd_op == lsag_pkg::LSAG_OP_MULTI &&
        cmd_reg_list == lsag_pkg::LSAG_NO_REGS) illegal = 1'b1;
    if (cmd_op == lsag_pkg::LSAG_OP_PCREL &&
        (cmd_pc_off < lsag_pkg::LSAG_PCREL_MIN)) illegal = 1'b1;
    if (cmd_op == lsag_pkg::LSAG_OP_PCREL_DUAL &&
        (cmd_pc_off < lsag_pkg::LSAG_DUAL_MIN ||
         cmd_pc_off > lsag_pkg::LSAG_DUAL_MAX)) illegal = 1'b1;
    // Program-counter-relative forms exist only as loads
    if ((cmd_op == lsag_pkg::LSAG_OP_PCREL ||
         cmd_op == lsag_pkg::LSAG_OP_PCREL_DUAL) && !cmd_load) illegal = 1'b1;
  end

  // First access address per addressing form
  always_comb begin
    case (cmd_op)
      lsag_pkg::LSAG_OP_REGOFF:
        start_addr = cmd_base_val + (cmd_offset_val << cmd_shift);
      lsag_pkg::LSAG_OP_UNPRIV:
        start_addr = cmd_base_val + {24'h00_0000, cmd_unpriv_imm};
      lsag_pkg::LSAG_OP_PCREL, lsag_pkg::LSAG_OP_PCREL_DUAL:
        start_addr = cmd_pc_val + {{19{cmd_pc_off[12]}}, cmd_pc_off};
      default:
        start_addr = cmd_base_val;
    endcase
  end

  // Register of the current beat and what is left of the list
  always_comb begin
    if (op_q == lsag_pkg::LSAG_OP_MULTI) begin
      cur_reg = (dir_q == lsag_pkg::LSAG_DIR_INC_AFTER) ? lsag_lowest(list_q)
                                                        : lsag_highest(list_q);
    end else begin
      cur_reg = beat2_q ? xfer2_q : xfer_q;
    end
    list_rest = list_q & ~(16'h0001 << cur_reg);
    more      = (op_q == lsag_pkg::LSAG_OP_MULTI) ? (list_rest != lsag_pkg::LSAG_NO_REGS)
              : (op_q == lsag_pkg::LSAG_OP_PCREL_DUAL) && !beat2_q;
    // Multiple and dual transfers move whole words only
    beat_size = (op_q == lsag_pkg::LSAG_OP_MULTI ||
                 op_q == lsag_pkg::LSAG_OP_PCREL_DUAL) ? lsag_pkg::LSAG_SZ_WORD
                                                       : size_q;
  end

  lsag_extend u_extend (
    .raw_data (mem_rdata),
    .size     (beat_size),
    .reg_data (ext_data)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Command capture and beat stepping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= LSAG_ST_IDLE;
      cmd_ready_q <= 1'b0;
      op_q        <= lsag_pkg::LSAG_OP_REGOFF;
      size_q      <= lsag_pkg::LSAG_SZ_WORD;
      dir_q       <= lsag_pkg::LSAG_DIR_INC_AFTER;
      load_q      <= 1'b0;
      unpriv_q    <= 1'b0;
      wb_q        <= 1'b0;
      beat2_q     <= 1'b0;
      xfer_q      <= 4'h0;
      xfer2_q     <= 4'h0;
      base_q      <= 4'h0;
      addr_q      <= lsag_pkg::LSAG_ZERO;
      list_q      <= lsag_pkg::LSAG_NO_REGS;
    end else begin
      case (state_q)
        LSAG_ST_IDLE: begin
          cmd_ready_q <= 1'b1;
          // Rejected or failed commands retire in IDLE without any access
          if (accept && cmd_cond_pass && !illegal) begin
            cmd_ready_q <= 1'b0;
            state_q     <= LSAG_ST_ISSUE;
            op_q        <= cmd_op;
            size_q      <= cmd_size;
            // Non-multiple forms step upward, so a dual load's second word is at +4
            dir_q       <= (cmd_op == lsag_pkg::LSAG_OP_MULTI)
                           ? lsag_pkg::lsag_multi_dir(cmd_multi_form, cmd_load)
                           : lsag_pkg::LSAG_DIR_INC_AFTER;
            load_q      <= cmd_load;
            // Privileged code loses its privilege only on the unprivileged forms
            unpriv_q    <= (cmd_op == lsag_pkg::LSAG_OP_UNPRIV) || !cmd_privileged;
            wb_q        <= cmd_writeback;
            beat2_q     <= 1'b0;
            xfer_q      <= cmd_xfer_reg;
            xfer2_q     <= cmd_xfer2_reg;
            base_q      <= cmd_base_reg;
            addr_q      <= start_addr;
            list_q      <= cmd_reg_list;
          end
        end
        LSAG_ST_ISSUE: state_q <= LSAG_ST_WAIT;
        LSAG_ST_WAIT: begin
          if (mem_ack) begin
            if (more) begin
              state_q <= LSAG_ST_ISSUE;
              beat2_q <= 1'b1;
              list_q  <= list_rest;
              addr_q  <= (dir_q == lsag_pkg::LSAG_DIR_DEC_BEFORE)
                         ? addr_q - lsag_pkg::LSAG_WORD_STEP
                         : addr_q + lsag_pkg::LSAG_WORD_STEP;
            end else begin
              state_q     <= LSAG_ST_IDLE;
              cmd_ready_q <= 1'b1;
            end
          end
        end
        default: state_q <= LSAG_ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Memory request
  // ==========================================================================
  // Beat signals are held stable until the acknowledge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_req_q    <= 1'b0;
      mem_write_q  <= 1'b0;
      mem_addr_q   <= lsag_pkg::LSAG_ZERO;
      mem_size_q   <= lsag_pkg::LSAG_BUS_WORD;
      mem_unpriv_q <= 1'b0;
      mem_reg_q    <= 4'h0;
    end else if (state_q == LSAG_ST_ISSUE) begin
      mem_req_q    <= 1'b1;
      mem_write_q  <= !load_q;
      mem_addr_q   <= addr_q;
      mem_size_q   <= lsag_pkg::lsag_bus_size(beat_size);
      mem_unpriv_q <= unpriv_q;
      mem_reg_q    <= cur_reg;
    end else if (beat_ack) begin
      mem_req_q    <= 1'b0;
    end
  end

  // ==========================================================================
  // Register results and branch
  // ==========================================================================
  // A program counter load becomes a branch, never a plain register write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rf_we_q     <= 1'b0;
      rf_idx_q    <= 4'h0;
      rf_data_q   <= lsag_pkg::LSAG_ZERO;
      br_valid_q  <= 1'b0;
      br_target_q <= lsag_pkg::LSAG_ZERO;
    end else begin
      rf_we_q    <= beat_ack && load_q && (cur_reg != lsag_pkg::LSAG_PC_IDX);
      br_valid_q <= beat_ack && load_q && (cur_reg == lsag_pkg::LSAG_PC_IDX);
      if (beat_ack && load_q) begin
        rf_idx_q    <= cur_reg;
        rf_data_q   <= ext_data;
        br_target_q <= mem_rdata & lsag_pkg::LSAG_HALF_MASK;
      end
    end
  end

  // Base writeback after the last beat; list never holds the base then
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bwb_we_q   <= 1'b0;
      bwb_idx_q  <= 4'h0;
      bwb_data_q <= lsag_pkg::LSAG_ZERO;
    end else begin
      bwb_we_q <= beat_ack && !more && wb_q &&
                  (op_q == lsag_pkg::LSAG_OP_MULTI);
      if (beat_ack && !more) begin
        bwb_idx_q  <= base_q;
        bwb_data_q <= addr_q;
      end
    end
  end

  // ==========================================================================
  // Status
  // ==========================================================================
  // Flag write enable exists so the core can merge it; it never rises
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q     <= 1'b0;
      reject_q   <= 1'b0;
      flags_we_q <= 1'b0;
    end else begin
      done_q     <= (accept && (!cmd_cond_pass || illegal)) || (beat_ack && !more);
      reject_q   <= accept && cmd_cond_pass && illegal;
      flags_we_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_inc_beat;
    beat_ack && more && op_q == lsag_pkg::LSAG_OP_MULTI && dir_q == lsag_pkg::LSAG_DIR_INC_AFTER;
  endsequence
  sequence s_dec_beat;
    beat_ack && more && op_q == lsag_pkg::LSAG_OP_MULTI && dir_q == lsag_pkg::LSAG_DIR_DEC_BEFORE;
  endsequence

  a_regoff_addr: assert property (@(posedge clk) disable iff (sys_rst)
    accept && cmd_cond_pass && !illegal && cmd_op == lsag_pkg::LSAG_OP_REGOFF |-> ##2
    mem_addr_q == $past(cmd_base_val, 2) + ($past(cmd_offset_val, 2) << $past(cmd_shift, 2)))
    else $error("register offset address wrong");
  a_sbyte_extend: assert property (@(posedge clk) disable iff (sys_rst)
    beat_ack && load_q && beat_size == lsag_pkg::LSAG_SZ_SBYTE && cur_reg != lsag_pkg::LSAG_PC_IDX
    |=> rf_we_q && rf_data_q == {{24{$past(mem_rdata[7])}}, $past(mem_rdata[7:0])})
    else $error("signed byte not sign extended");
  a_signed_store: assert property (@(posedge clk) disable iff (sys_rst)
    accept && cmd_cond_pass && !cmd_load && cmd_op != lsag_pkg::LSAG_OP_MULTI &&
    cmd_size == lsag_pkg::LSAG_SZ_SHALF |=> reject_q ##1 !mem_req_q)
    else $error("signed store accepted");
  a_branch_align: assert property (@(posedge clk) disable iff (sys_rst)
    br_valid_q |-> !br_target_q[0] && !rf_we_q && br_target_q[31:1] == $past(mem_rdata[31:1]))
    else $error("branch target wrong");
  a_flags_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !flags_we_q) else $error("flags written");
  a_unpriv_attr: assert property (@(posedge clk) disable iff (sys_rst)
    mem_req_q && op_q == lsag_pkg::LSAG_OP_UNPRIV |-> mem_unpriv_q)
    else $error("unprivileged attribute missing");
  a_pcrel_range: assert property (@(posedge clk) disable iff (sys_rst)
    accept && cmd_cond_pass && cmd_load && cmd_op == lsag_pkg::LSAG_OP_PCREL_DUAL &&
    cmd_pc_off > lsag_pkg::LSAG_DUAL_MAX |=> reject_q && done_q)
    else $error("dual offset out of range accepted");
  a_inc_step: assert property (@(posedge clk) disable iff (sys_rst)
    s_inc_beat |-> ##2 mem_addr_q == $past(mem_addr_q, 2) + lsag_pkg::LSAG_WORD_STEP &&
    mem_reg_q > $past(mem_reg_q, 2)) else $error("increment step wrong");
  a_dec_step: assert property (@(posedge clk) disable iff (sys_rst)
    s_dec_beat |-> ##2 mem_addr_q == $past(mem_addr_q, 2) - lsag_pkg::LSAG_WORD_STEP &&
    mem_reg_q < $past(mem_reg_q, 2)) else $error("decrement step wrong");
  a_wb_final: assert property (@(posedge clk) disable iff (sys_rst)
    bwb_we_q |-> bwb_data_q == $past(mem_addr_q) && done_q)
    else $error("writeback address wrong");
  a_cond_fail: assert property (@(posedge clk) disable iff (sys_rst)
    accept && !cmd_cond_pass |=> done_q && !reject_q && !mem_req_q ##1 !mem_req_q)
    else $error("failed condition had effect");

endmodule : lsag_core

// ==== verification/lsag_mem_model.sv ====
/*
  Memory partner: acks each beat after lat idle cycles and returns ~address.
  Assumes the core holds a beat's request until it sees the ack.
*/
module lsag_mem_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Beat from the core
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  lat,
  // Answer
  output logic             ack,
  output logic [31:0]      rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q;
  logic       tg_q;
  // ==========================================================================
  // One-cycle ack pulse; slow answers stall the core
  always_ff @(posedge clk) begin
    tg_q <= sys_rst ? 1'b0 : ~tg_q;
    if (sys_rst || !req || ack) begin
      ack   <= 1'b0;
      cnt_q <= 2'h0;
    end else if (cnt_q == lat) begin
      ack <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // Idle data toggles so a stale read never looks valid
  assign rdata = ack ? ~addr : {32{tg_q}};
endmodule : lsag_mem_model

// ==== verification/load_store_address_gen_bench.sv ====
/*
  Self-checking bench for lsag_core with a memory partner.
  Assumes the core's hand-over timing; inputs change on the falling edge.
*/
module load_store_address_gen_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, cmd_valid, cmd_load, cmd_cond_pass, cmd_privileged, cmd_writeback;
  logic [3:0] cmd_xfer_reg, cmd_base_reg, ri[8];
  logic [31:0] cmd_base_val, cmd_offset_val, cmd_pc_val, ba[8], rfd, brt, bwd;
  logic [1:0] cmd_shift, lat;
  logic [7:0] cmd_unpriv_imm;
  logic signed [12:0] cmd_pc_off;
  logic [15:0] cmd_reg_list;
  lsag_pkg::lsag_op_t cmd_op;
  lsag_pkg::lsag_size_t cmd_size;
  lsag_pkg::lsag_mform_t cmd_multi_form;
  logic cmd_ready_q, mem_req_q, mem_write_q, mem_unpriv_q, mem_ack, rf_we_q, bwb_we_q;
  logic br_valid_q, done_q, reject_q, flags_we_q, up, dn, rj;
  logic [31:0] mem_addr_q, mem_rdata, rf_data_q, bwb_data_q, br_target_q;
  logic [3:0] mem_reg_q, rf_idx_q, bwb_idx_q;
  lsag_pkg::lsag_bus_size_t mem_size_q;
  int num_errors, tests_run, nb, nrf, nbr, nbw, cyc;
  lsag_core u_dut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_ready_q(cmd_ready_q), .cmd_op(cmd_op), .cmd_load(cmd_load), .cmd_size(cmd_size),
    .cmd_cond_pass(cmd_cond_pass), .cmd_privileged(cmd_privileged),
    .cmd_xfer_reg(cmd_xfer_reg), .cmd_xfer2_reg(4'h3), .cmd_base_reg(cmd_base_reg),
    .cmd_base_val(cmd_base_val), .cmd_offset_val(cmd_offset_val), .cmd_shift(cmd_shift),
    .cmd_unpriv_imm(cmd_unpriv_imm), .cmd_pc_val(cmd_pc_val), .cmd_pc_off(cmd_pc_off),
    .cmd_reg_list(cmd_reg_list), .cmd_multi_form(cmd_multi_form),
    .cmd_writeback(cmd_writeback), .mem_req_q(mem_req_q), .mem_write_q(mem_write_q),
    .mem_addr_q(mem_addr_q), .mem_size_q(mem_size_q), .mem_unpriv_q(mem_unpriv_q),
    .mem_reg_q(mem_reg_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rf_we_q(rf_we_q),
    .rf_idx_q(rf_idx_q), .rf_data_q(rf_data_q), .bwb_we_q(bwb_we_q), .bwb_idx_q(bwb_idx_q),
    .bwb_data_q(bwb_data_q), .br_valid_q(br_valid_q), .br_target_q(br_target_q),
    .done_q(done_q), .reject_q(reject_q), .flags_we_q(flags_we_q));
  lsag_mem_model u_mem (.clk(clk), .sys_rst(sys_rst), .req(mem_req_q),
    .addr(mem_addr_q), .lat(lat), .ack(mem_ack), .rdata(mem_rdata));
  // ==========================================================================
  // Clock, and a monitor that logs results and cuts a hang short
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (mem_req_q && mem_ack) begin
      ba[nb] = mem_addr_q; ri[nb] = mem_reg_q; up = mem_unpriv_q; nb++;
    end
    if (rf_we_q === 1'b1) begin rfd = rf_data_q; nrf++; end
    if (br_valid_q === 1'b1) begin brt = br_target_q; nbr++; end
    if (bwb_we_q === 1'b1) begin bwd = bwb_data_q; nbw++; end
    dn |= (done_q === 1'b1);
    rj |= (reject_q === 1'b1);
    if (flags_we_q !== 1'b0) num_errors++;
    if (++cyc == 6000) begin num_errors++; test_done(); end
  end
  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin num_errors++; $display("wrong value at %0t: %s", $time, what); end
  endtask : chk
  // Offer one command, then wait a bounded time for it to retire
  task automatic go;
    nb = 0; nrf = 0; nbr = 0; nbw = 0; dn = 0; rj = 0;
    @(negedge clk) cmd_valid = 1'b1;
    while (!cmd_ready_q) @(negedge clk);
    @(negedge clk) cmd_valid = 1'b0;
    for (int k = 0; k < 60 && !dn; k++) @(negedge clk);
    chk(dn, "no retire");
  endtask : go
  function automatic logic [31:0] ext(input lsag_pkg::lsag_size_t s, input logic [31:0] v);
    case (s)
      lsag_pkg::LSAG_SZ_UBYTE: return {24'h0, v[7:0]};
      lsag_pkg::LSAG_SZ_UHALF: return {16'h0, v[15:0]};
      lsag_pkg::LSAG_SZ_SBYTE: return {{24{v[7]}}, v[7:0]};
      lsag_pkg::LSAG_SZ_SHALF: return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction : ext
  // ==========================================================================
  // Scenarios; operands avoid SP/PC misuse
  task automatic t_regoff;
    for (int s = 0; s < 4; s++) begin
      cmd_shift = s[1:0]; lat = s[1:0]; cmd_privileged = s[0]; go();
      chk(ba[0] === 32'h1000 + (32'h10 << s), "offset address");
      chk(rfd === ~ba[0] && up === ~cmd_privileged, "word load");
    end
    cmd_xfer_reg = lsag_pkg::LSAG_PC_IDX; cmd_base_val = 32'h2ff2; cmd_shift = 2'h0; go();
    chk(brt === 32'hffffcffc && nbr == 1 && nrf == 0, "branch target");
    cmd_cond_pass = 1'b0; go();
    chk(nb == 0 && nbr == 0 && nrf == 0, "failed condition acted");
    cmd_cond_pass = 1'b1; cmd_xfer_reg = 4'h2;
  endtask : t_regoff
  task automatic t_unpriv;
    cmd_op = lsag_pkg::LSAG_OP_UNPRIV; cmd_base_val = 32'h2001; cmd_unpriv_imm = 8'hff;
    for (int z = 1; z < 5; z++) begin
      cmd_size = lsag_pkg::lsag_size_t'(z); go();
      chk(ba[0] === 32'h2100 && up === 1'b1, "unprivileged beat");
      chk(rfd === ext(cmd_size, 32'hffffdeff), "extension");
    end
    cmd_load = 1'b0; go();
    chk(rj && nb == 0, "signed store taken");
  endtask : t_unpriv
  task automatic t_multi;
    cmd_op = lsag_pkg::LSAG_OP_MULTI; cmd_base_val = 32'h4000; cmd_reg_list = 16'h002a;
    for (int f = 0; f < 10; f++) begin
      logic dec;
      cmd_multi_form = lsag_pkg::lsag_mform_t'(f / 2); cmd_load = f[0];
      cmd_writeback = f[1]; lat = f[1:0];
      dec = (f / 2 == 2) || (f / 2 == 3 && !f[0]) || (f / 2 == 4 && f[0]);
      go();
      for (int b = 0; b < 3; b++) begin
        chk(ba[b] === (dec ? 32'h4000 - 4 * b : 32'h4000 + 4 * b), "beat");
        chk(ri[b] === (dec ? 4'h5 - 2 * b : 4'h1 + 2 * b), "order");
      end
      chk(nbw == f[1] && (!f[1] || bwd === ba[2]), "writeback");
    end
    cmd_reg_list = 16'h0000; go();
    chk(rj && nb == 0, "empty list taken");
  endtask : t_multi
  // Dual load: pair order and offset limit; a leftover decrement form must not leak in
  task automatic t_pcrel;
    cmd_op = lsag_pkg::LSAG_OP_PCREL_DUAL; cmd_load = 1'b1; cmd_pc_val = 32'h8000;
    cmd_pc_off = 13'sh03fc; cmd_multi_form = lsag_pkg::LSAG_MF_DEC; go();
    chk(ba[0] === 32'h83fc && ba[1] === 32'h8400 && ri[1] === 4'h3, "dual pair");
    cmd_pc_off = 13'sh0400; go();
    chk(rj && nb == 0, "dual range");
  endtask : t_pcrel
  task automatic test_done;
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    {cmd_valid, cmd_writeback, cmd_shift, lat, cmd_pc_off, cmd_reg_list} = '0;
    {sys_rst, cmd_load, cmd_cond_pass, cmd_privileged} = 4'hf;
    cmd_op = lsag_pkg::LSAG_OP_REGOFF; cmd_size = lsag_pkg::LSAG_SZ_WORD;
    cmd_multi_form = lsag_pkg::LSAG_MF_DEFAULT; cmd_xfer_reg = 4'h2; cmd_base_reg = 4'h6;
    cmd_base_val = 32'h1000; cmd_offset_val = 32'h10; cmd_unpriv_imm = 8'h0;
    cmd_pc_val = 32'h0; num_errors = 0; tests_run = 0; cyc = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_regoff();
    t_unpriv();
    t_multi();
    t_pcrel();
    test_done();
  end
endmodule : load_store_address_gen_bench
